// ===== rtl/ddc_cmd_port.sv
// Two-wire command port and register update logic of a dual 10-bit DAC
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"

// What this block does
// - Acknowledge own write address and three bytes.
// - Repeated start, read address acknowledged, then transmit.
// - Return channel code as two bytes, MSB first.
// - Both channels selected starts readback at A.
// - Readback order A, four fillers, then B.
// - Keep incrementing; after B wrap to A.
// - Command 0100 sets power-down from low byte.
// - Modes: normal, 1k, 100k, three-state.
// - Powered-down channel disconnects amplifier; 1k and 100k modes select network.
// - Power-down keeps DAC code; writes still accepted.
// - Each channel has input and DAC register.
// - Strobe low: write 0001 loads both registers.
// - Strobe high: input only; falling strobe loads.
// - Frame fields: command, selects, ten-bit code.
// - Address is 00011 plus two select pins.
// - 0010 copies input; 0011 writes both registers.
module ddc_cmd_port (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Two-wire link
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Address select straps
  input wire logic i_addr_select_pin_hi,
  input wire logic i_addr_select_pin_lo,
  // Load strobe, active low
  input wire logic i_load_strobe_n,
  // Converter codes
  output var ddc_pkg::ddc_code_type o_dac_a,
  output var ddc_pkg::ddc_code_type o_dac_b,
  // Power-down mode bits
  output logic o_chan_a_pwrdn_hi,
  output logic o_chan_a_pwrdn_lo,
  output logic o_chan_b_pwrdn_hi,
  output logic o_chan_b_pwrdn_lo,
  // Output stage switches, index 0 is A
  output logic [1:0] o_amp_conn,
  output logic [1:0] o_res_1k,
  output logic [1:0] o_res_100k
);
  import ddc_pkg::*;

  // ---------------- Link domain (SCL) ----------------
  logic start_tog; // Flips on every start condition
  logic start_seen; // Last start toggle acted on
  ddc_st_type state; // Protocol state
  ddc_st_type next_state;
  logic [3:0] cnt; // Bit position within byte, 8 is ack slot
  logic [3:0] next_cnt;
  logic [6:0] shreg; // Received bits so far
  logic [7:0] byte0; // Command byte
  logic [7:0] byte1; // Data high byte
  logic [1:0] byte_idx; // Byte number within frame
  logic ack; // Acknowledge the byte just received
  logic addr_ok; // Address matched
  logic addr_rd; // Read requested
  logic [2:0] rd_start; // Readback start index
  logic [2:0] rd_idx; // Readback byte index
  logic [23:0] frame_word; // Last complete frame
  logic frame_tog; // Flips on every complete frame
  logic [2:0] asel_sync [2]; // Strap synchronisers, index 0 is low pin
  logic [1:0] asel; // Stable strap value
  ddc_code_type in_reg [2]; // Input registers
  logic sda_low; // Open-drain level, always low

  // Start detect on SDA's own falling edge while SCL is high.
  // SDA settles three quarters of an SCL period before the next rising edge,
  // so the toggle is stable when the link logic compares it.
  always_ff @(negedge i_sda_in or posedge i_rst) begin
    if (i_rst) begin
      start_tog <= 1'b0;
    end else if (i_scl) begin
      start_tog <= ~start_tog;
    end
  end

  // Decode of the incoming bit stream
  wire start_new = start_tog != start_seen;
  wire [7:0] rx_byte = {shreg, i_sda_in};
  wire last_data = cnt == `DDC_LAST_BIT;
  wire ack_slot = cnt == `DDC_ACK_BIT;
  wire addr_match = rx_byte[7:1] == {`DDC_ADDR_HI, asel};
  wire frame_done = (state == ST_WRITE) && last_data
    && (byte_idx == `DDC_LAST_BYTE);
  wire [23:0] word_now = {byte0, byte1, rx_byte};
  wire [3:0] cmd_now = word_now[`DDC_CMD_MSB:`DDC_CMD_LSB];
  wire [1:0] sel_now = {word_now[`DDC_SELB_BIT], word_now[`DDC_SELA_BIT]};
  wire wr_input = (cmd_now == `DDC_CMD_WR) || (cmd_now == `DDC_CMD_WRUPD);
  // Readback byte: A pair, four fillers, B pair
  wire rd_filler = rd_idx[2] != rd_idx[1];
  wire [9:0] rd_code = rd_idx[2] ? in_reg[1] : in_reg[0];
  wire [7:0] tx_byte = rd_filler ? 8'h00 :
    (rd_idx[0] ? {rd_code[1:0], 6'h00} : rd_code[9:2]);
  wire [2:0] bit_sel = 3'h7 - cnt[2:0];
  wire next_oe = (ack_slot && ack) ||
    ((state == ST_READ) && !ack_slot && !tx_byte[bit_sel]);

  // Next protocol state
  always_comb begin
    next_state = state;
    if (start_new) begin
      next_state = ST_ADDR;
    end else if (ack_slot) begin
      unique case (state)
        ST_ADDR: next_state = !addr_ok ? ST_IDLE :
          (addr_rd ? ST_READ : ST_WRITE);
        ST_READ: next_state = i_sda_in ? ST_IDLE : ST_READ;
        ST_IDLE, ST_WRITE: next_state = state;
      endcase
    end
  end

  // Next bit position
  always_comb begin
    next_cnt = cnt + 4'h1;
    if (start_new) begin
      next_cnt = 4'h1;
    end else if (state == ST_IDLE || ack_slot) begin
      next_cnt = 4'h0;
    end
  end

  // State and bit counter
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      start_seen <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      start_seen <= start_tog;
    end
  end

  // Strap synchronisers, settle within the first address bits
  wire [1:0] asel_pin = {i_addr_select_pin_hi, i_addr_select_pin_lo};
  for (genvar sb = 0; sb < 2; sb++) begin : g_strap
    // Three flops; value taken once second and third agree
    always_ff @(posedge i_scl or posedge i_rst) begin
      if (i_rst) begin
        asel_sync[sb] <= 3'h0;
        asel[sb] <= 1'b0;
      end else begin
        asel_sync[sb] <= {asel_sync[sb][1:0], asel_pin[sb]};
        asel[sb] <= (asel_sync[sb][1] == asel_sync[sb][2])
          ? asel_sync[sb][2] : asel[sb];
      end
    end
  end

  // Shift register and frame bytes
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      shreg <= 7'h00;
      byte0 <= 8'h00;
      byte1 <= 8'h00;
      byte_idx <= 2'h0;
    end else begin
      shreg <= start_new ? {6'h00, i_sda_in} : rx_byte[6:0];
      if (start_new) begin
        byte_idx <= 2'h0;
      end else if (state == ST_WRITE && last_data) begin
        byte0 <= (byte_idx == 2'h0) ? rx_byte : byte0;
        byte1 <= (byte_idx == 2'h1) ? rx_byte : byte1;
        byte_idx <= frame_done ? 2'h0 : byte_idx + 2'h1;
      end
    end
  end

  // Acknowledge decision and address flags
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      ack <= 1'b0;
      addr_ok <= 1'b0;
      addr_rd <= 1'b0;
    end else if (start_new) begin
      ack <= 1'b0;
    end else if (last_data) begin
      ack <= (state == ST_WRITE) || (state == ST_ADDR && addr_match);
      addr_ok <= addr_match;
      addr_rd <= rx_byte[0];
    end
  end

  // Readback pointer: control byte picks start, acks advance
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      rd_start <= `DDC_RD_A_IDX;
      rd_idx <= `DDC_RD_A_IDX;
    end else if (state == ST_WRITE && last_data && byte_idx == 2'h0) begin
      rd_start <= (rx_byte[0] || !rx_byte[3]) ? `DDC_RD_A_IDX
        : `DDC_RD_B_IDX;
    end else if (ack_slot && state == ST_ADDR) begin
      rd_idx <= rd_start;
    end else if (ack_slot && state == ST_READ && !i_sda_in) begin
      rd_idx <= rd_idx + 3'h1;
    end
  end

  // Frame capture and handoff toggle
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      frame_word <= 24'h000000;
      frame_tog <= 1'b0;
    end else if (frame_done) begin
      frame_word <= word_now;
      frame_tog <= ~frame_tog;
    end
  end

  // SDA drive changes on the falling SCL edge only
  always_ff @(negedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      o_sda_oe <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      o_sda_oe <= next_oe;
      sda_low <= 1'b0;
    end
  end
  assign o_sda_out = sda_low;

  // ---------------- System domain (i_clk), input registers on i_scl ----------------
  logic [2:0] frame_sync; // Frame toggle synchroniser
  logic frame_seen; // Last frame toggle acted on
  logic [2:0] strobe_sync; // Load strobe synchroniser
  logic strobe_lvl; // Stable strobe level
  ddc_code_type dac [2]; // DAC registers
  ddc_code_type in_img [2]; // Input register images, avoids word crossing
  ddc_mode_type pd [2]; // Power-down modes

  // Event decode after the second and third flops agree
  wire frame_ev = (frame_sync[1] == frame_sync[2])
    && (frame_sync[2] != frame_seen);
  wire strobe_fall = (strobe_sync[1] == strobe_sync[2])
    && !strobe_sync[2] && strobe_lvl;
  wire [3:0] fcmd = frame_word[`DDC_CMD_MSB:`DDC_CMD_LSB];
  wire f_wr_input = (fcmd == `DDC_CMD_WR) || (fcmd == `DDC_CMD_WRUPD);
  wire [1:0] fsel = {frame_word[`DDC_SELB_BIT], frame_word[`DDC_SELA_BIT]};
  wire [9:0] fcode = frame_word[`DDC_CODE_MSB:`DDC_CODE_LSB];
  wire ld_code = (fcmd == `DDC_CMD_WRUPD) ||
    ((fcmd == `DDC_CMD_WR) && !strobe_lvl);
  wire ld_copy = fcmd == `DDC_CMD_UPD;
  wire pd_ev = frame_ev && (fcmd == `DDC_CMD_PWR);
  wire [1:0] fpd [2];
  assign fpd[0] = frame_word[`DDC_PDA_MSB:`DDC_PDA_LSB];
  assign fpd[1] = frame_word[`DDC_PDB_MSB:`DDC_PDB_LSB];

  // Synchronisers for the frame toggle and the load strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_sync <= 3'h0;
      frame_seen <= 1'b0;
      strobe_sync <= 3'h7;
      strobe_lvl <= 1'b1;
    end else begin
      frame_sync <= {frame_sync[1:0], frame_tog};
      frame_seen <= frame_ev ? frame_sync[2] : frame_seen;
      strobe_sync <= {strobe_sync[1:0], i_load_strobe_n};
      strobe_lvl <= (strobe_sync[1] == strobe_sync[2]) ? strobe_sync[2]
        : strobe_lvl;
    end
  end

  // Per-channel register pair and output stage
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wire hit = frame_ev && fsel[ch];
    // Frame code wins over a same-cycle strobe copy
    wire [9:0] next_dac = (hit && ld_code) ? fcode :
      ((hit && ld_copy) || strobe_fall) ? in_img[ch] : dac[ch];
    // Image follows the link-side input register from the frame word
    wire [9:0] next_img = (hit && f_wr_input) ? fcode : in_img[ch];
    wire [1:0] next_pd = pd_ev ? fpd[ch] : pd[ch];

    // Input register written by the link on the 24th bit
    always_ff @(posedge i_scl or posedge i_rst) begin
      if (i_rst) begin
        in_reg[ch] <= 10'h000;
      end else if (frame_done && wr_input && sel_now[ch]) begin
        in_reg[ch] <= word_now[`DDC_CODE_MSB:`DDC_CODE_LSB];
      end
    end

    // DAC register, mode and stage switches
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        dac[ch] <= 10'h000;
        in_img[ch] <= 10'h000;
        pd[ch] <= `DDC_PD_NORMAL;
        o_amp_conn[ch] <= 1'b1;
        o_res_1k[ch] <= 1'b0;
        o_res_100k[ch] <= 1'b0;
      end else begin
        dac[ch] <= next_dac;
        in_img[ch] <= next_img;
        pd[ch] <= next_pd;
        o_amp_conn[ch] <= next_pd == `DDC_PD_NORMAL;
        o_res_1k[ch] <= next_pd == `DDC_PD_1K;
        o_res_100k[ch] <= next_pd == `DDC_PD_100K;
      end
    end
  end

  // Output wiring from the flops
  assign o_dac_a = dac[0];
  assign o_dac_b = dac[1];
  assign o_chan_a_pwrdn_hi = pd[0][1];
  assign o_chan_a_pwrdn_lo = pd[0][0];
  assign o_chan_b_pwrdn_hi = pd[1][1];
  assign o_chan_b_pwrdn_lo = pd[1][0];

  // ---------------- Checks ----------------
  write_ack_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (ack_slot && state == ST_WRITE && !start_new) |-> o_sda_oe)
    else $error("write byte not acknowledged");
  idle_release_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (state == ST_IDLE) |-> !o_sda_oe)
    else $error("SDA driven while idle");
  read_bit_a: assert property (@(posedge i_scl) disable iff (i_rst)
    (state == ST_READ && !ack_slot && !start_new)
      |-> (o_sda_oe == !tx_byte[bit_sel]))
    else $error("readback bit wrong");
  pd_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    pd_ev |=> (pd[0] == $past(fpd[0])) && (pd[1] == $past(fpd[1])))
    else $error("power-down mode not taken");
  stage_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    pd_ev |=> (o_amp_conn[0] == ($past(fpd[0]) == `DDC_PD_NORMAL))
      && (o_res_1k[0] == ($past(fpd[0]) == `DDC_PD_1K))
      && (o_res_100k[1] == ($past(fpd[1]) == `DDC_PD_100K)))
    else $error("output stage mismatch");
  pd_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (pd_ev && !strobe_fall) |=> $stable(o_dac_a) && $stable(o_dac_b))
    else $error("power-down altered code");
  direct_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (frame_ev && fsel[0] && fcmd == `DDC_CMD_WR && !strobe_lvl)
      |=> o_dac_a == $past(fcode))
    else $error("direct load missed");
  defer_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (strobe_fall && !frame_ev) |=> o_dac_b == $past(in_img[1]))
    else $error("strobe load missed");
  copy_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (frame_ev && fsel[0] && fcmd == `DDC_CMD_UPD)
      |=> o_dac_a == $past(in_img[0]))
    else $error("update command failed");
  reserved_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (frame_ev && (fcmd >= `DDC_CMD_RSV || fcmd == `DDC_CMD_NOP)
      && !strobe_fall) |=> $stable(o_dac_a) && $stable(pd[0]))
    else $error("reserved command had effect");
endmodule : ddc_cmd_port
`default_nettype wire

// ===== rtl/ddc_params.svh
// Constants of the dual DAC two-wire command port
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// Fixed upper five bits of the slave address
`define DDC_ADDR_HI 5'h03

// Command codes in frame bits 23:20
`define DDC_CMD_NOP 4'h0
`define DDC_CMD_WR 4'h1
`define DDC_CMD_UPD 4'h2
`define DDC_CMD_WRUPD 4'h3
`define DDC_CMD_PWR 4'h4
`define DDC_CMD_RSV 4'h8

// Frame field positions
`define DDC_CMD_MSB 23
`define DDC_CMD_LSB 20
`define DDC_SELB_BIT 19
`define DDC_SELA_BIT 16
`define DDC_CODE_MSB 15
`define DDC_CODE_LSB 6
`define DDC_PDB_MSB 7
`define DDC_PDB_LSB 6
`define DDC_PDA_MSB 1
`define DDC_PDA_LSB 0

// Bit counter marks: last data bit and acknowledge slot
`define DDC_LAST_BIT 4'h7
`define DDC_ACK_BIT 4'h8
`define DDC_LAST_BYTE 2'h2

// Readback byte indices where channels A and B start
`define DDC_RD_A_IDX 3'h0
`define DDC_RD_B_IDX 3'h6

// Power-down mode encodings
`define DDC_PD_NORMAL 2'h0
`define DDC_PD_1K 2'h1
`define DDC_PD_100K 2'h2
`define DDC_PD_TRI 2'h3

`endif

// ===== rtl/ddc_pkg.sv
// Types shared by the dual DAC command port
package ddc_pkg;
  // Ten-bit converter code
  typedef logic [9:0] ddc_code_type;
  // Two-bit power-down mode
  typedef logic [1:0] ddc_mode_type;
  // Link-side protocol state
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ} ddc_st_type;
endpackage : ddc_pkg

// ===== test/ddc_master.sv
// Two-wire bus master model that drives the command port
`timescale 1ns/1ps
`default_nettype none
module ddc_master (
  // Link wires, data released means pulled up
  output logic o_scl,
  output logic o_sda_m,
  input wire logic i_sda
);
  // Clock parked high and data released between frames
  initial begin
    o_scl = 1'b1;
    o_sda_m = 1'b1;
  end
  // One bit slot: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    o_scl = 1'b0;
    #3 o_sda_m = b;
    #3 o_scl = 1'b1;
    #3 r = i_sda;
    #3;
  endtask : bit_io
  // Start or repeated start: data falls while clock is high
  task automatic start;
    #1 o_scl = 1'b0;
    #3 o_sda_m = 1'b1;
    #3 o_scl = 1'b1;
    #3 o_sda_m = 1'b0;
    #3;
  endtask : start
  // Stop: data rises while clock is high, clock then parks
  task automatic stop;
    o_scl = 1'b0;
    #3 o_sda_m = 1'b0;
    #3 o_scl = 1'b1;
    #3 o_sda_m = 1'b1;
    #3;
  endtask : stop
  // Send a byte MSB first, return the acknowledge level
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask : tx
  // Receive a byte; a high acknowledge ends the readback
  task automatic rx(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, r);
  endtask : rx
endmodule : ddc_master
`default_nettype wire

// ===== test/ddc_cmd_port_test.sv
// Self-checking bench of the dual DAC command port
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin \
  failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module ddc_cmd_port_test;
  import ddc_pkg::*;
  // Clock, reset and pins
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strobe_n = 1'b1;
  logic sel_hi = 1'b1;
  logic sel_lo = 1'b0;
  logic scl, sda_m, sda, sda_out, sda_oe;
  logic pa_hi, pa_lo, pb_hi, pb_lo;
  logic [1:0] amp, r1k, r100k;
  ddc_code_type dac_a, dac_b;
  // Input register images and bookkeeping
  logic [9:0] ia, ib;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [6:0] adr = {`DDC_ADDR_HI, 2'b10};
  // Open-drain wire: low if either party pulls
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  always #20 clk = ~clk;
  ddc_cmd_port dut_u (.i_clk(clk), .i_rst(rst), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_addr_select_pin_hi(sel_hi), .i_addr_select_pin_lo(sel_lo),
    .i_load_strobe_n(strobe_n), .o_dac_a(dac_a), .o_dac_b(dac_b),
    .o_chan_a_pwrdn_hi(pa_hi), .o_chan_a_pwrdn_lo(pa_lo),
    .o_chan_b_pwrdn_hi(pb_hi), .o_chan_b_pwrdn_lo(pb_lo),
    .o_amp_conn(amp), .o_res_1k(r1k), .o_res_100k(r100k));
  ddc_master m_u (.o_scl(scl), .o_sda_m(sda_m), .i_sda(sda));
  // Verdict and end of run
  task automatic close_out;
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  // Full 24-bit write frame, every byte must be acknowledged
  task automatic wr24(input logic [23:0] f);
    logic a;
    m_u.start();
    m_u.tx({adr, 1'b0}, a);
    `CHK("ack adr", 1'b0, a)
    for (int i = 2; i >= 0; i--) begin
      m_u.tx(f[i*8 +: 8], a);
      `CHK("ack byte", 1'b0, a)
    end
    m_u.stop();
    repeat (8) @(posedge clk);
    #1;
  endtask : wr24
  // Command, channel selects {B, A} and ten-bit code
  task automatic wr(input logic [3:0] c, input logic [1:0] s,
                    input logic [9:0] v);
    wr24({c, s[1], 2'b00, s[0], v, 6'h00});
  endtask : wr
  // Strobe pin change, then time for the synchroniser
  task automatic pin(input logic v);
    @(posedge clk);
    strobe_n <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask : pin
  // Both DAC register codes
  task automatic chk_dac(input logic [9:0] a, input logic [9:0] b);
    `CHK("dac_a", a, dac_a)
    `CHK("dac_b", b, dac_b)
  endtask : chk_dac
  // Expected readback byte at sequence position k
  function automatic logic [7:0] rb(input int k);
    case (k % 8)
      0: rb = ia[9:2];
      1: rb = {ia[1:0], 6'h00};
      6: rb = ib[9:2];
      7: rb = {ib[1:0], 6'h00};
      default: rb = 8'h00;
    endcase
  endfunction : rb
  // Readback: control byte, repeated start, n bytes from position k0
  task automatic rd(input logic [7:0] ctl, input int k0, input int n);
    logic a;
    logic [7:0] d;
    m_u.start();
    m_u.tx({adr, 1'b0}, a);
    m_u.tx(ctl, a);
    `CHK("ack ctl", 1'b0, a)
    m_u.start();
    m_u.tx({adr, 1'b1}, a);
    `CHK("ack rd adr", 1'b0, a)
    for (int k = 0; k < n; k++) begin
      m_u.rx(k == n - 1, d);
      `CHK("rb byte", rb(k0 + k), d)
    end
    m_u.stop();
  endtask : rd
  // Main sequence
  initial begin
    logic a;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_dac(10'h000, 10'h000);
    `CHK("amp rst", 2'h3, amp)
    `CHK("pd rst", 4'h0, {pa_hi, pa_lo, pb_hi, pb_lo})
    pin(1'b0);
    wr(4'h1, 2'h1, 10'h2AB);
    chk_dac(10'h2AB, 10'h000);
    pin(1'b1);
    wr(4'h1, 2'h2, 10'h155);
    chk_dac(10'h2AB, 10'h000);
    pin(1'b0);
    chk_dac(10'h2AB, 10'h155);
    pin(1'b1);
    wr(4'h1, 2'h1, 10'h011);
    wr(4'h2, 2'h1, 10'h000);
    chk_dac(10'h011, 10'h155);
    wr(4'h3, 2'h2, 10'h0F0);
    chk_dac(10'h011, 10'h0F0);
    for (int c = 0; c < 16; c = (c == 0) ? 8 : c + 1) begin
      wr(4'(c), 2'h3, 10'h3FF);
    end
    chk_dac(10'h011, 10'h0F0);
    for (int m = 0; m < 4; m++) begin
      wr24({16'h4000, 2'(3 - m), 4'hF, 2'(m)});
      `CHK("pd a", 2'(m), {pa_hi, pa_lo})
      `CHK("pd b", 2'(3 - m), {pb_hi, pb_lo})
      `CHK("amp", {m == 3, m == 0}, amp)
      `CHK("r1k", {m == 2, m == 1}, r1k)
      `CHK("r100k", {m == 1, m == 2}, r100k)
    end
    wr(4'h3, 2'h1, 10'h200);
    chk_dac(10'h200, 10'h0F0);
    `CHK("pd kept", 2'h3, {pa_hi, pa_lo})
    wr24(24'h40003C);
    ia = 10'h200;
    ib = 10'h0F0;
    rd(8'h19, 0, 10);
    rd(8'h18, 6, 2);
    m_u.start();
    m_u.tx({7'h0C, 1'b0}, a);
    `CHK("foreign adr", 1'b1, a)
    m_u.tx(8'h31, a);
    `CHK("foreign byte", 1'b1, a)
    m_u.stop();
    repeat (8) @(posedge clk);
    chk_dac(10'h200, 10'h0F0);
    // Straps moved: new address answers, old one is foreign
    @(posedge clk);
    sel_hi <= 1'b0;
    sel_lo <= 1'b1;
    adr = {`DDC_ADDR_HI, 2'b01};
    wr(4'h3, 2'h1, 10'h155);
    chk_dac(10'h155, 10'h0F0);
    m_u.start();
    m_u.tx({7'h0E, 1'b0}, a);
    `CHK("old adr", 1'b1, a)
    m_u.stop();
    close_out();
  end
endmodule : ddc_cmd_port_test
`default_nettype wire
